// ==== rtl/arpc_top.sv ====
// arpc_top: power, reference, reference DAC and oscillator control registers
// of the converter module, reached over its internal two-wire bus.
// assumes bus pins and the converter power-off level from the neighbouring
// control register are synchronous to I_SYS_CLK.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - power register bit 7 enables common reference
// - DAC code: high reg bits 11-4, low 3-0
// - low code write waits until high write
// - DAC control bit 7 enables reference DAC
// - DAC control bit 6: supply or common reference
// - bandgap off only when powered off, reference disabled
// - oscillator stable flag after 16 oscillator clocks
// - unimplemented bits read zero, ignore writes
// - registers accessed over internal two-wire bus
module arpc_top
(
    // clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_SYS_RST,
    // internal two-wire bus; SDA is open drain, output is always low
    input wire logic I_SCL,
    input wire logic I_SDA_IN,
    output logic O_SDA_OUT,
    output logic O_SDA_OE,
    // neighbouring converter control
    input wire logic I_CONVERTER_POWER_OFF,
    // analog controls
    output logic O_COMMON_REF_ENABLE,
    output logic O_BANDGAP_ON,
    output logic [6:0] O_PERF_TUNING,
    output logic O_REF_DAC_ENABLE,
    output logic O_REF_DAC_SOURCE_SELECT,
    output logic [arpc_pkg::DAC_CODE_W-1:0] O_REF_DAC_CODE,
    // oscillator
    output logic O_OSC_ENABLE,
    output logic O_OSC_STABLE_FLAG,
    output logic O_OSC_CLOCK_OUTPUT
);
    import arpc_pkg::*;

    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
        reg_hit = (addr == ofs);
    endfunction

    logic bus_wr_en;
    logic [7:0] bus_addr;
    logic [7:0] bus_wr_data;
    logic [7:0] rd_data;
    logic sda_oe;

    logic [7:0] pwr_ref_ctrl_r;
    logic [7:0] dac_code_high_r;
    logic [DAC_LOW_W-1:0] dac_low_shadow_r;
    logic [DAC_LOW_W-1:0] dac_code_low_r;
    logic ref_dac_enable_r;
    logic ref_dac_source_select_r;
    logic osc_enable_r;
    logic osc_clock_output_r;
    logic [OSC_CNT_W-1:0] osc_cnt_r;
    logic osc_stable_flag_r;
    logic bandgap_on_r;
    logic [9:0] en_age_r;

    // bus access over the two-wire slave
    arpc_i2c_slave u_i2c_slave
    (
        .i_clk(I_SYS_CLK),
        .i_rst(I_SYS_RST),
        .i_scl(I_SCL),
        .i_sda(I_SDA_IN),
        .o_sda_oe(sda_oe),
        .o_wr_en(bus_wr_en),
        .o_addr(bus_addr),
        .o_wr_data(bus_wr_data),
        .i_rd_data(rd_data)
    );

    assign O_SDA_OUT = 1'b0;
    assign O_SDA_OE = sda_oe;

    // read view; unimplemented bits tie low
    always_comb
    begin
        rd_data = 8'h00;
        if (reg_hit(bus_addr, PWR_REF_CTRL_OFS))
            rd_data = pwr_ref_ctrl_r;
        else if (reg_hit(bus_addr, DAC_CODE_HIGH_OFS))
            rd_data = dac_code_high_r;
        else if (reg_hit(bus_addr, DAC_CODE_LOW_OFS))
            rd_data[DAC_LOW_W-1:0] = dac_low_shadow_r;
        else if (reg_hit(bus_addr, DAC_CTRL_OFS))
        begin
            rd_data[REF_DAC_EN_BIT] = ref_dac_enable_r;
            rd_data[REF_DAC_SRC_BIT] = ref_dac_source_select_r;
        end
        else if (reg_hit(bus_addr, OSC_CTRL_OFS))
        begin
            rd_data[OSC_EN_BIT] = osc_enable_r;
            rd_data[OSC_STABLE_BIT] = osc_stable_flag_r;
            rd_data[OSC_CLK_OUT_BIT] = osc_clock_output_r;
        end
    end

    // power register: enable bit plus tuning field, the field is the host's
    // to set correctly for the filter mode
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
            pwr_ref_ctrl_r <= PWR_REF_CTRL_RST;
        else if (bus_wr_en && reg_hit(bus_addr, PWR_REF_CTRL_OFS))
            pwr_ref_ctrl_r <= bus_wr_data;
    end

    // low code is parked in a shadow until the high byte arrives, so the
    // analog code never shows a half-updated value
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            dac_low_shadow_r <= DAC_CODE_LOW_RST;
            dac_code_low_r <= DAC_CODE_LOW_RST;
            dac_code_high_r <= DAC_CODE_HIGH_RST;
        end
        else
        begin
            if (bus_wr_en && reg_hit(bus_addr, DAC_CODE_LOW_OFS))
                dac_low_shadow_r <= bus_wr_data[DAC_LOW_W-1:0];
            if (bus_wr_en && reg_hit(bus_addr, DAC_CODE_HIGH_OFS))
            begin
                dac_code_high_r <= bus_wr_data;
                dac_code_low_r <= dac_low_shadow_r;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            ref_dac_enable_r <= DAC_EN_RST;
            ref_dac_source_select_r <= DAC_SRC_RST;
        end
        else if (bus_wr_en && reg_hit(bus_addr, DAC_CTRL_OFS))
        begin
            ref_dac_enable_r <= bus_wr_data[REF_DAC_EN_BIT];
            ref_dac_source_select_r <= bus_wr_data[REF_DAC_SRC_BIT];
        end
    end

    // clock-output bit is stored but the host keeps it at zero
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            osc_enable_r <= OSC_EN_RST;
            osc_clock_output_r <= OSC_CLK_OUT_RST;
        end
        else if (bus_wr_en && reg_hit(bus_addr, OSC_CTRL_OFS))
        begin
            osc_enable_r <= bus_wr_data[OSC_EN_BIT];
            osc_clock_output_r <= bus_wr_data[OSC_CLK_OUT_BIT];
        end
    end

    // settling count in system cycles covering 16 oscillator periods;
    // the flag itself is read-only, writes to its bit are dropped
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            osc_cnt_r <= '0;
            osc_stable_flag_r <= 1'b0;
        end
        else if (!osc_enable_r)
        begin
            osc_cnt_r <= '0;
            osc_stable_flag_r <= 1'b0;
        end
        else if (osc_cnt_r < OSC_CNT_W'(OSC_STABLE_CYC))
        begin
            osc_cnt_r <= osc_cnt_r + 1'b1;
            osc_stable_flag_r <= (osc_cnt_r == OSC_CNT_W'(OSC_STABLE_CYC - 1));
        end
    end

    // bandgap stays up unless the converter is off and the reference unused
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
            bandgap_on_r <= BANDGAP_RST;
        else
            bandgap_on_r <= !(I_CONVERTER_POWER_OFF && !pwr_ref_ctrl_r[COMMON_REF_EN_BIT]);
    end

    assign O_COMMON_REF_ENABLE = pwr_ref_ctrl_r[COMMON_REF_EN_BIT];
    assign O_BANDGAP_ON = bandgap_on_r;
    assign O_PERF_TUNING = pwr_ref_ctrl_r[TUNING_MSB:0];
    assign O_REF_DAC_ENABLE = ref_dac_enable_r;
    assign O_REF_DAC_SOURCE_SELECT = ref_dac_source_select_r;
    assign O_REF_DAC_CODE = {dac_code_high_r, dac_code_low_r};
    assign O_OSC_ENABLE = osc_enable_r;
    assign O_OSC_STABLE_FLAG = osc_stable_flag_r;
    assign O_OSC_CLOCK_OUTPUT = osc_clock_output_r;

    // cycles since the oscillator was last enabled, only for checking
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
            en_age_r <= 10'h000;
        else if (!osc_enable_r)
            en_age_r <= 10'h000;
        else if (en_age_r != 10'h3FF)
            en_age_r <= en_age_r + 10'h001;
    end

    a_common_ref_write: assert property (
        @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        bus_wr_en && bus_addr == PWR_REF_CTRL_OFS
        |=> O_COMMON_REF_ENABLE == $past(bus_wr_data[7]))
    else $error("common reference enable does not follow power register bit 7");

    a_dac_high_commit: assert property (
        @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        bus_wr_en && bus_addr == DAC_CODE_HIGH_OFS
        |=> O_REF_DAC_CODE == {$past(bus_wr_data), $past(dac_low_shadow_r)})
    else $error("dac code not formed from high byte and buffered low bits");

    a_dac_low_held: assert property (
        @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        bus_wr_en && bus_addr == DAC_CODE_LOW_OFS
        |=> $stable(O_REF_DAC_CODE) ##1 $stable(O_REF_DAC_CODE) || $past(bus_wr_en))
    else $error("low dac code write reached the output without a high write");

    a_dac_enable_write: assert property (
        @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        bus_wr_en && bus_addr == DAC_CTRL_OFS
        |=> O_REF_DAC_ENABLE == $past(bus_wr_data[7]))
    else $error("dac enable does not follow control bit 7");

    a_dac_source_write: assert property (
        @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        bus_wr_en && bus_addr == DAC_CTRL_OFS
        |=> O_REF_DAC_SOURCE_SELECT == $past(bus_wr_data[6]))
    else $error("dac source select does not follow control bit 6");

    a_bandgap_table: assert property (
        @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        I_CONVERTER_POWER_OFF && !O_COMMON_REF_ENABLE
        |=> !O_BANDGAP_ON)
    else $error("bandgap on while converter off and reference disabled");

    a_bandgap_on: assert property (
        @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        !I_CONVERTER_POWER_OFF || O_COMMON_REF_ENABLE |=> O_BANDGAP_ON)
    else $error("bandgap off while converter or reference needs it");

    a_osc_stable_time: assert property (
        @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        $rose(O_OSC_STABLE_FLAG) |-> en_age_r == 10'(OSC_STABLE_CYC) && O_OSC_ENABLE)
    else $error("oscillator stable flag set at the wrong settling time");

    a_osc_not_late: assert property (
        @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        O_OSC_ENABLE && en_age_r == 10'(OSC_STABLE_CYC) |-> O_OSC_STABLE_FLAG)
    else $error("oscillator stable flag late");

    a_osc_disable_clear: assert property (
        @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        !O_OSC_ENABLE |=> !O_OSC_STABLE_FLAG)
    else $error("oscillator stable flag survived disable");

    a_unimpl_read_zero: assert property (
        @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        (bus_addr == DAC_CTRL_OFS |-> rd_data[5:0] == 6'h00)
        and (bus_addr == OSC_CTRL_OFS |-> rd_data[7:3] == 5'h00)
        and (bus_addr == DAC_CODE_LOW_OFS |-> rd_data[7:4] == 4'h0))
    else $error("unimplemented register bits read non-zero");

    // writes outside the map must leave every stored bit alone
    a_unmapped_write: assert property (
        @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        bus_wr_en && bus_addr != PWR_REF_CTRL_OFS && bus_addr != DAC_CODE_HIGH_OFS
        && bus_addr != DAC_CODE_LOW_OFS && bus_addr != DAC_CTRL_OFS && bus_addr != OSC_CTRL_OFS
        |=> $stable({pwr_ref_ctrl_r, dac_code_high_r, dac_low_shadow_r, dac_code_low_r,
                     ref_dac_enable_r, ref_dac_source_select_r, osc_enable_r,
                     osc_clock_output_r}))
    else $error("write to an unmapped index changed a register");

    a_low_shadow_load: assert property (
        @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        bus_wr_en && bus_addr == DAC_CODE_LOW_OFS
        |=> dac_low_shadow_r == $past(bus_wr_data[DAC_LOW_W-1:0]))
    else $error("low dac code write did not reach the holding buffer");

    a_osc_restart: assert property (
        @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        $rose(O_OSC_ENABLE) |-> !O_OSC_STABLE_FLAG ##1 !O_OSC_STABLE_FLAG)
    else $error("oscillator stable flag set right after enable");

endmodule

`default_nettype wire

// ==== rtl/arpc_pkg.sv ====
// arpc_pkg: register map, field layout, reset values and timing of the
// converter power and reference control section.
// assumes a 100 MHz system clock and the register-index addressing of the
// module's internal two-wire bus.
package arpc_pkg;

    // register indexes on the internal two-wire bus
    localparam logic [7:0] PWR_REF_CTRL_OFS = 8'h00;
    localparam logic [7:0] DAC_CODE_HIGH_OFS = 8'h0B;
    localparam logic [7:0] DAC_CODE_LOW_OFS = 8'h0C;
    localparam logic [7:0] DAC_CTRL_OFS = 8'h0D;
    localparam logic [7:0] OSC_CTRL_OFS = 8'h11;

    // field positions
    localparam int COMMON_REF_EN_BIT = 7;
    localparam int TUNING_MSB = 6;
    localparam int REF_DAC_EN_BIT = 7;
    localparam int REF_DAC_SRC_BIT = 6;
    localparam int OSC_EN_BIT = 0;
    localparam int OSC_STABLE_BIT = 1;
    localparam int OSC_CLK_OUT_BIT = 2;
    localparam int DAC_CODE_W = 12;
    localparam int DAC_LOW_W = 4;

    // reset values
    localparam logic [7:0] PWR_REF_CTRL_RST = 8'h00;
    localparam logic [7:0] DAC_CODE_HIGH_RST = 8'h00;
    localparam logic [3:0] DAC_CODE_LOW_RST = 4'h0;
    localparam logic DAC_EN_RST = 1'b0;
    localparam logic DAC_SRC_RST = 1'b0;
    localparam logic OSC_EN_RST = 1'b1;
    localparam logic OSC_CLK_OUT_RST = 1'b0;
    localparam logic BANDGAP_RST = 1'b1;

    // two-wire slave address of this section; value is arbitrary
    localparam logic [6:0] DEV_ADDR = 7'h48;

    // oscillator settling: 16 oscillator clocks, converted to system cycles
    localparam longint SYS_CLK_HZ = 100000000;
    localparam longint OSC_FREQ_HZ = 4915200;
    localparam longint OSC_STABLE_CLOCKS = 16;
    localparam int OSC_STABLE_CYC =
        int'((OSC_STABLE_CLOCKS * SYS_CLK_HZ + OSC_FREQ_HZ - 1) / OSC_FREQ_HZ);
    localparam int OSC_CNT_W = 9;

    typedef enum logic [2:0]
    {
        I2C_IDLE,
        I2C_DEV,
        I2C_PTR,
        I2C_WDATA,
        I2C_RDATA
    } arpc_i2c_state_t;

endpackage

// ==== rtl/arpc_i2c_slave.sv ====
// arpc_i2c_slave: two-wire slave that turns bus transfers into register
// write pulses and register reads, using the register index as address.
// assumes SCL and SDA are already synchronous to the system clock and far
// slower than it; no clock stretching.
`timescale 1ns/100ps
`default_nettype none

module arpc_i2c_slave
(
    // system
    input wire logic i_clk,
    input wire logic i_rst,
    // bus pins
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_oe,
    // register side
    output logic o_wr_en,
    output logic [7:0] o_addr,
    output logic [7:0] o_wr_data,
    input wire logic [7:0] i_rd_data
);
    import arpc_pkg::*;

    arpc_i2c_state_t state_r;
    logic scl_q_r;
    logic sda_q_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic read_r;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    assign scl_rise = i_scl & ~scl_q_r;
    assign scl_fall = ~i_scl & scl_q_r;
    assign start_det = scl_q_r & i_scl & sda_q_r & ~i_sda;
    assign stop_det = scl_q_r & i_scl & ~sda_q_r & i_sda;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end
        else
        begin
            scl_q_r <= i_scl;
            sda_q_r <= i_sda;
        end
    end

    // bytes are acked on the falling edge after the 8th bit; pointer
    // advances after every data byte so bursts walk the register map
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_r <= I2C_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            read_r <= 1'b0;
            o_sda_oe <= 1'b0;
            o_wr_en <= 1'b0;
            o_addr <= 8'h00;
            o_wr_data <= 8'h00;
        end
        else
        begin
            o_wr_en <= 1'b0;
            if (start_det)
            begin
                state_r <= I2C_DEV;
                bit_cnt_r <= 4'h0;
                o_sda_oe <= 1'b0;
            end
            else if (stop_det)
            begin
                state_r <= I2C_IDLE;
                o_sda_oe <= 1'b0;
            end
            else if (state_r == I2C_RDATA)
            begin
                if (scl_fall && bit_cnt_r < 4'h7)
                begin
                    shift_r <= {shift_r[6:0], 1'b0};
                    o_sda_oe <= ~shift_r[6];
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                end
                else if (scl_fall && bit_cnt_r == 4'h7)
                begin
                    o_sda_oe <= 1'b0;
                    bit_cnt_r <= 4'h8;
                end
                else if (scl_rise && bit_cnt_r == 4'h8)
                begin
                    if (i_sda)
                        state_r <= I2C_IDLE;
                    else
                        bit_cnt_r <= 4'h9;
                end
                else if (scl_fall && bit_cnt_r == 4'h9)
                begin
                    shift_r <= i_rd_data;
                    o_sda_oe <= ~i_rd_data[7];
                    o_addr <= o_addr + 8'h01;
                    bit_cnt_r <= 4'h0;
                end
            end
            else if (state_r != I2C_IDLE)
            begin
                if (scl_rise && bit_cnt_r < 4'h8)
                begin
                    shift_r <= {shift_r[6:0], i_sda};
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                end
                else if (scl_fall && bit_cnt_r == 4'h8)
                begin
                    bit_cnt_r <= 4'h9;
                    o_sda_oe <= 1'b1;
                    case (state_r)
                        I2C_DEV:
                        begin
                            read_r <= shift_r[0];
                            if (shift_r[7:1] != DEV_ADDR)
                            begin
                                state_r <= I2C_IDLE;
                                o_sda_oe <= 1'b0;
                            end
                        end
                        I2C_PTR: o_addr <= shift_r;
                        I2C_WDATA:
                        begin
                            o_wr_en <= 1'b1;
                            o_wr_data <= shift_r;
                        end
                        default: o_sda_oe <= 1'b0;
                    endcase
                end
                else if (scl_fall && bit_cnt_r == 4'h9)
                begin
                    bit_cnt_r <= 4'h0;
                    o_sda_oe <= 1'b0;
                    case (state_r)
                        I2C_DEV:
                        begin
                            if (read_r)
                            begin
                                state_r <= I2C_RDATA;
                                shift_r <= i_rd_data;
                                o_sda_oe <= ~i_rd_data[7];
                                o_addr <= o_addr + 8'h01;
                            end
                            else
                                state_r <= I2C_PTR;
                        end
                        I2C_PTR: state_r <= I2C_WDATA;
                        I2C_WDATA: o_addr <= o_addr + 8'h01;
                        default: state_r <= I2C_IDLE;
                    endcase
                end
            end
        end
    end

endmodule

`default_nettype wire

// ==== tb/arpc_i2c_host.sv ====
// arpc_i2c_host: behavioural two-wire bus master for the register section.
// assumes SDA is resolved outside with a pull-up; drives 1 ns after a clock edge.
`timescale 1ns/100ps
`default_nettype none

module arpc_i2c_host
(
    // system
    input wire logic i_clk,
    // bus
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    import arpc_pkg::*;
    localparam int HALF = 4;
    initial
    begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // sda is set in the low phase and sampled at the end of the high phase
    task automatic slot(input logic b, output logic s);
        o_sda_low = !b;
        tick(HALF);
        o_scl = 1'b1;
        tick(HALF);
        s = i_sda;
        o_scl = 1'b0;
        tick(1);
    endtask
    // also serves as a repeated start from a low clock
    task automatic start();
        o_sda_low = 1'b0;
        tick(HALF);
        o_scl = 1'b1;
        tick(HALF);
        o_sda_low = 1'b1;
        tick(HALF);
        o_scl = 1'b0;
        tick(1);
    endtask
    task automatic stop();
        o_sda_low = 1'b1;
        tick(HALF);
        o_scl = 1'b1;
        tick(HALF);
        o_sda_low = 1'b0;
        tick(HALF);
    endtask
    task automatic put(input logic [7:0] d, inout logic miss);
        logic s;
        for (int i = 7; i >= 0; i--)
            slot(d[i], s);
        slot(1'b1, s);
        miss = miss | s;
    endtask
    // register index is the first byte after the address
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] idx,
                             input logic [7:0] d, output logic miss);
        miss = 1'b0;
        start();
        put({dev, 1'b0}, miss);
        put(idx, miss);
        put(d, miss);
        stop();
    endtask
    task automatic read_reg(input logic [7:0] idx, output logic [7:0] d,
                            output logic miss);
        logic s;
        miss = 1'b0;
        start();
        put({DEV_ADDR, 1'b0}, miss);
        put(idx, miss);
        start();
        put({DEV_ADDR, 1'b1}, miss);
        for (int i = 7; i >= 0; i--)
            slot(1'b1, d[i]);
        // a not-acknowledge ends the single-byte read
        slot(1'b1, s);
        stop();
    endtask
endmodule

`default_nettype wire

// ==== tb/adc_reference_power_control_test.sv ====
// adc_reference_power_control_test: self-checking bench of the power, reference,
// DAC and oscillator registers. assumes arpc_i2c_host and a pulled-up SDA.
`timescale 1ns/100ps
`default_nettype none

module adc_reference_power_control_test;
    import arpc_pkg::*;
    logic clk;
    logic rst;
    logic scl;
    logic sda_low;
    logic sda_wire;
    logic sda_out;
    logic sda_oe;
    logic pwr_off;
    logic ref_en;
    logic bandgap;
    logic [6:0] tuning;
    logic dac_en;
    logic dac_src;
    logic [DAC_CODE_W-1:0] code;
    logic osc_en;
    logic osc_ok;
    logic osc_out;
    int fails;
    int checks;

    assign sda_wire = !(sda_low || (sda_oe && !sda_out));

    arpc_top uut
    (
        .I_SYS_CLK(clk),
        .I_SYS_RST(rst),
        .I_SCL(scl),
        .I_SDA_IN(sda_wire),
        .O_SDA_OUT(sda_out),
        .O_SDA_OE(sda_oe),
        .I_CONVERTER_POWER_OFF(pwr_off),
        .O_COMMON_REF_ENABLE(ref_en),
        .O_BANDGAP_ON(bandgap),
        .O_PERF_TUNING(tuning),
        .O_REF_DAC_ENABLE(dac_en),
        .O_REF_DAC_SOURCE_SELECT(dac_src),
        .O_REF_DAC_CODE(code),
        .O_OSC_ENABLE(osc_en),
        .O_OSC_STABLE_FLAG(osc_ok),
        .O_OSC_CLOCK_OUTPUT(osc_out)
    );

    arpc_i2c_host host
    (
        .i_clk(clk),
        .i_sda(sda_wire),
        .o_scl(scl),
        .o_sda_low(sda_low)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic bg_exp(input logic off, input logic ref_on);
        return !(off && !ref_on);
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic miss;
        host.write_reg(DEV_ADDR, idx, d, miss);
        check(16'(miss), 16'h0000);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        logic miss;
        host.read_reg(idx, d, miss);
        check({7'h00, miss, d}, {8'h00, exp});
    endtask

    // the whole run needs roughly 18k cycles
    initial
    begin
        #900000;
        fails++;
        conclude();
    end

    initial
    begin
        logic [7:0] d;
        logic [7:0] p;
        logic [3:0] lo;
        logic [11:0] code_exp;
        logic miss;
        fails = 0;
        checks = 0;
        code_exp = 12'h000;
        rst = 1'b1;
        pwr_off = 1'b0;
        void'($urandom(97303));
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        check({2'b00, ref_en, bandgap, tuning, dac_en, dac_src, osc_en, osc_ok, osc_out},
              {2'b00, 1'b0, BANDGAP_RST, 7'h00, 4'b0010, 1'b0});
        check(16'(code), 16'h0000);
        repeat (OSC_STABLE_CYC - 1) @(posedge clk);
        #1;
        check(16'(osc_ok), 16'h0000);
        @(posedge clk);
        #1;
        check(16'(osc_ok), 16'h0001);
        rd(OSC_CTRL_OFS, 8'h03);
        // first four passes walk every power-off and reference-enable pair
        for (int i = 0; i < 8; i++)
        begin
            p = {(i < 4) ? i[0] : 1'($urandom), ($urandom & 1) ? 7'h28 : 7'h3C};
            pwr_off = (i < 4) ? i[1] : 1'($urandom);
            wr(PWR_REF_CTRL_OFS, p);
            check({8'h00, ref_en, tuning}, {8'h00, p});
            check(16'(bandgap), 16'(bg_exp(pwr_off, p[7])));
            rd(PWR_REF_CTRL_OFS, p);
        end
        for (int i = 0; i < 6; i++)
        begin
            d = 8'($urandom);
            lo = d[3:0];
            wr(DAC_CODE_LOW_OFS, d);
            check(16'(code), 16'(code_exp));
            rd(DAC_CODE_LOW_OFS, {4'h0, lo});
            d = (i == 0) ? 8'hFF : 8'($urandom);
            wr(DAC_CODE_HIGH_OFS, d);
            code_exp = {d, lo};
            check(16'(code), 16'(code_exp));
            rd(DAC_CODE_HIGH_OFS, d);
        end
        for (int i = 0; i < 4; i++)
        begin
            d = {i[1:0], 6'($urandom)};
            wr(DAC_CTRL_OFS, d);
            check({14'h0000, dac_en, dac_src}, {14'h0000, d[7:6]});
            rd(DAC_CTRL_OFS, d & 8'hC0);
        end
        d = {5'($urandom), 3'b000};
        wr(OSC_CTRL_OFS, d);
        check({13'h0000, osc_en, osc_ok, osc_out}, 16'h0000);
        rd(OSC_CTRL_OFS, 8'h00);
        fork
            wr(OSC_CTRL_OFS, d | 8'h01);
            begin
                @(posedge osc_en);
                repeat (OSC_STABLE_CYC - 1) @(posedge clk);
                #1;
                check(16'(osc_ok), 16'h0000);
                @(posedge clk);
                #1;
                check(16'(osc_ok), 16'h0001);
            end
        join
        // a foreign device address must be left unanswered and change nothing
        host.write_reg(DEV_ADDR ^ 7'h01, PWR_REF_CTRL_OFS, 8'h00, miss);
        check(16'(miss), 16'h0001);
        check({8'h00, ref_en, tuning}, {8'h00, p});
        wr(8'h05, 8'hFF);
        rd(8'h05, 8'h00);
        rd(PWR_REF_CTRL_OFS, p);
        conclude();
    end
endmodule

`default_nettype wire
